//--- design/sstc_pkg.sv
// constants, offsets and types shared by the supply and tick control block
package sstc_pkg;
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned SLOW_PERIOD_US = 1000;
   localparam int unsigned SLOW_CYCLES    = SLOW_PERIOD_US * CLK_MHZ;
   localparam int unsigned FAST_BASE_MHZ  = 8;
   localparam int unsigned FAST_CYCLES    = CLK_MHZ / FAST_BASE_MHZ;
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned CMP_W          = 7;
   localparam int unsigned KEY_W          = 4;
   // register byte addresses
   localparam logic [7:0] OFS_PWR1 = 8'h00;
   localparam logic [7:0] OFS_PWR3 = 8'h04;
   localparam logic [7:0] OFS_TICK = 8'h08;
   localparam logic [7:0] OFS_OPT1 = 8'h0C;
   localparam logic [7:0] OFS_CLK  = 8'h10;
   localparam logic [7:0] OFS_MODE = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   // power_control_one fields
   localparam int unsigned P1_EN = 0, P1_RST = 1, P1_IRQ = 2, P1_KEEP = 3, P1_ACK = 6, P1_FLAG = 7;
   // power_control_three fields
   localparam int unsigned P3_DLVL = 0, P3_WLVL = 1, P3_WACK = 5, P3_WFLAG = 7;
   // tick_status_control fields
   localparam int unsigned TK_FLAG = 7, TK_ACK = 6, TK_CLKS = 5, TK_IE = 4;
   // system_options_one fields
   localparam int unsigned O1_TRE = 0, O1_TRH = 1;
   // mode register fields
   localparam int unsigned MD_REFUSED = 3;
   // reset_source_status fields
   localparam int unsigned ST_POR = 7, ST_LVD = 1;
   // comparator vector positions
   localparam int unsigned C_POR = 0, C_DHI = 1, C_DLO = 2, C_WHI = 3, C_WLO = 4, C_TLO = 5, C_THI = 6;
   localparam logic [1:0] REQ_LIGHT = 2'h1;
   localparam logic [1:0] REQ_DEEP  = 2'h2;
   localparam logic [1:0] DIV_RST   = 2'h0;
   typedef enum logic [2:0] {
      MODE_RUN   = 3'h1,
      MODE_LIGHT = 3'h2,
      MODE_DEEP  = 3'h4
   } sstc_mode_t;
endpackage

//--- design/sstc_tick_if.sv
// carrier between the control registers and the periodic tick timer
`timescale 1ns/1ps
`default_nettype none
interface sstc_tick_if;
   logic [2:0] periodSel;
   logic       clkSel;
   logic       runMode;
   logic [1:0] divSel;
   logic       tickEvent;
   modport ctrl  (output periodSel, clkSel, runMode, divSel, input tickEvent);
   modport timer (input periodSel, clkSel, runMode, divSel, output tickEvent);
endinterface // sstc_tick_if
`default_nettype wire

//--- design/sstc_sync2.sv
// two-flop synchroniser for the analog comparator outputs
`timescale 1ns/1ps
`default_nettype none
module sstc_sync2 #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            meta[i] <= 1'b0;
            q[i]    <= 1'b0;
         end else begin
            meta[i] <= d[i];
            q[i]    <= meta[i];
         end
      end
   end
endmodule // sstc_sync2
`default_nettype wire

//--- design/sstc_tick.sv
// periodic tick timer with slow and fast source prescalers
`timescale 1ns/1ps
`default_nettype none
module sstc_tick
   import sstc_pkg::*;
#(
   parameter int unsigned SLOW_DIV = SLOW_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   sstc_tick_if.timer tk
);
   logic [17:0] slowCnt;
   logic [7:0]  fastCnt;
   logic [7:0]  perCnt;
   logic        evt;
   // free running, nothing in software can stop the slow prescaler
   wire slowTick = (slowCnt == 18'(SLOW_DIV - 1));
   wire [7:0] fastLast = 8'((FAST_CYCLES << tk.divSel) - 1);
   wire fastTick = (fastCnt == fastLast);
   // fast prescaler runs freely; its ticks reach the period counter only while running
   wire srcTick = tk.clkSel ? (fastTick & tk.runMode) : slowTick;
   wire [7:0] perLast = 8'((9'h001 << tk.periodSel) - 9'h001);
   wire hit = srcTick && (tk.periodSel != 3'h0) && (perCnt == perLast);
   assign tk.tickEvent = evt;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         slowCnt <= 18'h0_0000;
         fastCnt <= 8'h00;
         perCnt  <= 8'h00;
         evt     <= 1'b0;
      end else begin
         slowCnt <= slowTick ? 18'h0_0000 : slowCnt + 18'h0_0001;
         fastCnt <= fastTick ? 8'h00 : fastCnt + 8'h01;
         evt     <= hit;
         if (tk.periodSel == 3'h0 || hit) begin
            perCnt <= 8'h00;
         end else if (srcTick) begin
            perCnt <= perCnt + 8'h01;
         end
      end
   end
endmodule // sstc_tick
`default_nettype wire

//--- design/sstc_top.sv
// supply monitor, reset hold, clock select, wake and periodic tick control
//
// Operation
// - detector runs only when enabled; level select picks high or low trip
// - entering any stop mode turns the detector off unless stop-keep set
// - stop-keep and enable both set refuse entry to deepest stop
// - power-up holds reset until supply above level, then marks por and low-voltage
// - with reset enable, low supply holds reset until recovery, marks low-voltage
// - with interrupt enable and no reset enable, low supply sets flag and interrupt
// - warning flag sets below warning level; clear ignored while still below
// - software writes one to warning clear; flag clears if supply allows
// - warning raises no interrupt; its level comes from a select bit
// - two-bit bus divider select, cleared by any reset
// - key inputs 0 to 3 on port a pins 0 to 3 wake the core
// - tick clocked by slow oscillator or, in run, fast source; interrupt in run, wakeup from low power
// - slow oscillator always runs; no software control stops it
// - tick flag bit 7 sets on tick in run or light stop; zero write ignored
// - writing one to acknowledge bit 6 clears tick flag; zero ignored
// - tick flag cleared by any reset and deepest stop exit
// - tick acknowledge bit reads zero and has no reset state
// - bit 5 selects slow or fast tick source; fast only in run
// - bit 4 enables tick interrupts; cleared by reset
// - period field 000 stops tick; 001 to 111 give 2 to 128 ms
// - in deepest stop a thermal return to normal wakes and resets
// - thermal wake armed by enable bit; polarity bit picks low or high condition
`timescale 1ns/1ps
`default_nettype none
module sstc_top #(
   parameter int unsigned SLOW_DIV = sstc_pkg::SLOW_CYCLES
) (
   input  wire logic                        ref_clk,
   input  wire logic                        nrst,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [sstc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output var  logic [31:0]                 prdata,
   output var  logic                        pready,
   output var  logic                        pslverr,
   input  wire logic [sstc_pkg::CMP_W-1:0]  analogCmp,
   input  wire logic [sstc_pkg::KEY_W-1:0]  keyWakeInput,
   output var  logic                        chipReset,
   output var  logic                        supplyIrq,
   output var  logic                        tickIrq,
   output var  logic                        wakeup,
   output var  logic [2:0]                  powerMode,
   output var  logic [1:0]                  busDividerSelect,
   output var  logic                        detectorOn,
   output var  logic                        slowOscOn
);
   import sstc_pkg::*;

   function automatic logic selLevel(input logic hi, input logic lo, input logic sel);
      selLevel = sel ? hi : lo;
   endfunction

   sstc_mode_t mode;
   sstc_mode_t next_mode;
   logic [CMP_W-1:0] cmp;
   logic detEn, detRstEn, detIrqEn, stopKeep, detLvlSel, warnLvlSel;
   logic tickClkSel, tickIrqEn, thermEn, thermPol;
   logic [2:0] tickPer;
   logic [1:0] busDiv;
   logic detFlag, warnFlag, tickFlag, porStat, lvdStat, refused;
   logic holdReset, causePor, causeSupply, tempPrev;

   // comparators are asynchronous to ref_clk
   sstc_sync2 #(.W(CMP_W)) i_sstc_sync2 (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .d       (analogCmp),
      .q       (cmp)
   );

   sstc_tick_if tk ();
   assign tk.periodSel = tickPer;
   assign tk.clkSel    = tickClkSel;
   assign tk.runMode   = (mode == MODE_RUN);
   assign tk.divSel    = busDiv;

   sstc_tick #(.SLOW_DIV(SLOW_DIV)) i_sstc_tick (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .tk      (tk.timer)
   );

   // bus decode
   wire [7:0] w8    = pwdata[7:0];
   wire setupDone   = psel & penable & ~pready;
   wire apbAcc      = psel & penable & pready;
   wire wrEn        = apbAcc & pwrite;
   wire hitPwr1     = (paddr == OFS_PWR1);
   wire hitPwr3     = (paddr == OFS_PWR3);
   wire hitTick     = (paddr == OFS_TICK);
   wire hitOpt1     = (paddr == OFS_OPT1);
   wire hitClk      = (paddr == OFS_CLK);
   wire hitMode     = (paddr == OFS_MODE);
   wire hitStat     = (paddr == OFS_STAT);
   wire mapped      = hitPwr1 | hitPwr3 | hitTick | hitOpt1 | hitClk | hitMode | hitStat;
   wire wrPwr1      = wrEn & hitPwr1;
   wire wrPwr3      = wrEn & hitPwr3;
   wire wrTick      = wrEn & hitTick;
   wire wrMode      = wrEn & hitMode;

   wire [7:0] rdPwr1 = {detFlag, 3'h0, stopKeep, detIrqEn, detRstEn, detEn};
   wire [7:0] rdPwr3 = {warnFlag, 5'h00, warnLvlSel, detLvlSel};
   // acknowledge bit is not stored, so it always reads zero
   wire [7:0] rdTick = {tickFlag, 1'b0, tickClkSel, tickIrqEn, 1'b0, tickPer};
   wire [7:0] rdOpt1 = {6'h00, thermPol, thermEn};
   wire [7:0] rdMode = {4'h0, refused, mode};
   wire [7:0] rdStat = {porStat, 5'h00, lvdStat, 1'b0};
   wire [7:0] rdMux  = hitPwr1 ? rdPwr1 :
                       hitPwr3 ? rdPwr3 :
                       hitTick ? rdTick :
                       hitOpt1 ? rdOpt1 :
                       hitClk  ? {6'h00, busDiv} :
                       hitMode ? rdMode :
                       hitStat ? rdStat : 8'h00;

   // supply detector
   wire belowDet  = selLevel(cmp[C_DHI], cmp[C_DLO], detLvlSel);
   wire belowWarn = selLevel(cmp[C_WHI], cmp[C_WLO], warnLvlSel);
   wire porNow    = cmp[C_POR];
   wire detActive = detEn & ((mode == MODE_RUN) | stopKeep);
   wire lvdTrip   = detActive & detRstEn & belowDet;
   wire detEvent  = detActive & detIrqEn & ~detRstEn & belowDet;
   // warning has no interrupt path at all
   wire warnEvent = detActive & belowWarn;

   // thermal restart watches the return from the selected extreme
   wire tempSel   = selLevel(cmp[C_THI], cmp[C_TLO], thermPol);
   wire thermTrip = thermEn & tempPrev & ~tempSel;

   // wake sources
   wire keyAny    = |keyWakeInput;
   wire tickEvt   = tk.tickEvent;
   wire lowPower  = (mode != MODE_RUN);
   wire wakeAny   = lowPower & (keyAny | tickEvt | ((mode == MODE_DEEP) & thermTrip));
   wire deepExit  = (mode == MODE_DEEP) & wakeAny;
   wire deepReq   = wrMode & (w8[1:0] == REQ_DEEP);
   wire refuseNow = deepReq & stopKeep & detEn & (mode == MODE_RUN);

   // reset hold: supply causes wait for recovery, a deep exit is one cycle
   wire supplyOk  = ~porNow & ~belowDet;
   wire relHold   = holdReset & (causeSupply ? supplyOk : 1'b1);
   wire enterHold = porNow | lvdTrip | deepExit;

   always_comb begin
      next_mode = mode;
      case (mode)
         MODE_RUN: begin
            if (wrMode && w8[1:0] == REQ_LIGHT) begin
               next_mode = MODE_LIGHT;
            end else if (deepReq && !refuseNow) begin
               next_mode = MODE_DEEP;
            end
         end
         MODE_LIGHT: begin
            if (wakeAny) begin
               next_mode = MODE_RUN;
            end
         end
         MODE_DEEP: begin
            if (wakeAny) begin
               next_mode = MODE_RUN;
            end
         end
         default: begin
            next_mode = MODE_RUN;
         end
      endcase
      if (holdReset) begin
         next_mode = MODE_RUN;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode <= MODE_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   // bus slave answers one cycle into the access phase
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setupDone;
         if (setupDone) begin
            prdata  <= {24'h00_0000, rdMux};
            pslverr <= ~mapped;
         end
      end
   end

   // reset hold; after nrst it behaves as a power-on hold
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         holdReset   <= 1'b1;
         causePor    <= 1'b1;
         causeSupply <= 1'b1;
         porStat     <= 1'b0;
         lvdStat     <= 1'b0;
      end else if (enterHold) begin
         holdReset   <= 1'b1;
         causePor    <= causePor | porNow;
         causeSupply <= causeSupply | porNow | lvdTrip;
      end else if (relHold) begin
         holdReset   <= 1'b0;
         porStat     <= causePor;
         lvdStat     <= causeSupply;
         causePor    <= 1'b0;
         causeSupply <= 1'b0;
      end
   end

   // control bits; the reset hold clears them like any core reset
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         {detEn, detRstEn, detIrqEn, stopKeep} <= 4'h0;
         {detLvlSel, warnLvlSel} <= 2'h0;
         {tickClkSel, tickIrqEn, tickPer} <= 5'h00;
         {thermEn, thermPol} <= 2'h0;
         busDiv <= DIV_RST;
      end else if (holdReset) begin
         {detEn, detRstEn, detIrqEn, stopKeep} <= 4'h0;
         {detLvlSel, warnLvlSel} <= 2'h0;
         {tickClkSel, tickIrqEn, tickPer} <= 5'h00;
         {thermEn, thermPol} <= 2'h0;
         busDiv <= DIV_RST;
      end else begin
         if (wrPwr1) begin
            {stopKeep, detIrqEn, detRstEn, detEn} <= {w8[P1_KEEP], w8[P1_IRQ], w8[P1_RST], w8[P1_EN]};
         end
         if (wrPwr3) begin
            {warnLvlSel, detLvlSel} <= {w8[P3_WLVL], w8[P3_DLVL]};
         end
         if (wrTick) begin
            tickClkSel <= w8[TK_CLKS];
            tickIrqEn  <= w8[TK_IE];
            tickPer    <= w8[2:0];
         end
         if (wrEn && hitOpt1) begin
            {thermPol, thermEn} <= {w8[O1_TRH], w8[O1_TRE]};
         end
         if (wrEn && hitClk) begin
            busDiv <= w8[1:0];
         end
      end
   end

   // sticky flags: hardware set wins over a software clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         detFlag  <= 1'b0;
         warnFlag <= 1'b0;
         tickFlag <= 1'b0;
         refused  <= 1'b0;
      end else if (holdReset) begin
         detFlag  <= 1'b0;
         warnFlag <= 1'b0;
         tickFlag <= 1'b0;
         refused  <= 1'b0;
      end else begin
         if (detEvent) begin
            detFlag <= 1'b1;
         end else if (wrPwr1 && w8[P1_ACK]) begin
            detFlag <= 1'b0;
         end
         // a clear while still below the level is ignored
         if (warnEvent) begin
            warnFlag <= 1'b1;
         end else if (wrPwr3 && w8[P3_WACK] && !belowWarn) begin
            warnFlag <= 1'b0;
         end
         if (deepExit) begin
            tickFlag <= 1'b0;
         end else if (tickEvt && (mode == MODE_RUN || mode == MODE_LIGHT)) begin
            tickFlag <= 1'b1;
         end else if (wrTick && w8[TK_ACK]) begin
            tickFlag <= 1'b0;
         end
         if (refuseNow) begin
            refused <= 1'b1;
         end else if (wrMode) begin
            refused <= 1'b0;
         end
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         supplyIrq  <= 1'b0;
         tickIrq    <= 1'b0;
         wakeup     <= 1'b0;
         detectorOn <= 1'b0;
         slowOscOn  <= 1'b0;
         tempPrev   <= 1'b0;
      end else begin
         supplyIrq  <= detFlag & detIrqEn;
         tickIrq    <= tickFlag & tickIrqEn;
         wakeup     <= wakeAny;
         detectorOn <= detActive;
         slowOscOn  <= 1'b1;
         tempPrev   <= tempSel;
      end
   end

   assign chipReset        = holdReset;
   assign powerMode        = mode;
   assign busDividerSelect = busDiv;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_deepThermal;
      (mode == MODE_DEEP) && thermTrip;
   endsequence
   sequence s_resetRun;
      chipReset && (mode == MODE_RUN) && !tickFlag;
   endsequence

   property p_det_stop_off;
      (mode != MODE_RUN && !stopKeep) |=> !detectorOn;
   endproperty
   a_det_stop_off: assert property (p_det_stop_off) else $error("detector left on in stop");

   property p_refuse_deep;
      refuseNow |=> (mode == MODE_RUN) && refused;
   endproperty
   a_refuse_deep: assert property (p_refuse_deep) else $error("deep stop not refused");

   property p_por_release;
      (chipReset && causePor && causeSupply && supplyOk && !enterHold) |=> !chipReset && porStat && lvdStat;
   endproperty
   a_por_release: assert property (p_por_release) else $error("power-on release status wrong");

   property p_lvd_reset;
      lvdTrip |=> chipReset [*2];
   endproperty
   a_lvd_reset: assert property (p_lvd_reset) else $error("low supply did not hold reset");

   property p_det_irq;
      (detEvent && !holdReset) |=> detFlag;
   endproperty
   a_det_irq: assert property (p_det_irq) else $error("detect flag not set");

   property p_warn_hold;
      (warnFlag && belowWarn && !holdReset) |=> warnFlag;
   endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("warning cleared while supply low");

   property p_warn_clear;
      (wrPwr3 && w8[P3_WACK] && !warnEvent && !belowWarn) |=> !warnFlag;
   endproperty
   a_warn_clear: assert property (p_warn_clear) else $error("warning clear ignored");

   property p_div_reset;
      chipReset |=> (busDividerSelect == DIV_RST);
   endproperty
   a_div_reset: assert property (p_div_reset) else $error("divider not cleared by reset");

   property p_tick_set;
      (tickEvt && mode != MODE_DEEP && !holdReset) |=> tickFlag ##1 (tickIrq == tickIrqEn);
   endproperty
   a_tick_set: assert property (p_tick_set) else $error("tick flag or irq wrong");

   property p_tick_ack;
      (wrTick && w8[TK_ACK] && !tickEvt) |=> !tickFlag;
   endproperty
   a_tick_ack: assert property (p_tick_ack) else $error("tick acknowledge failed");

   property p_ack_reads_zero;
      (pready && !pwrite && hitTick) |-> !prdata[TK_ACK];
   endproperty
   a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("acknowledge bit read one");

   property p_thermal_wake;
      s_deepThermal |=> s_resetRun;
   endproperty
   a_thermal_wake: assert property (p_thermal_wake) else $error("thermal exit did not reset");

   property p_osc_on;
      slowOscOn |=> slowOscOn;
   endproperty
   a_osc_on: assert property (p_osc_on) else $error("slow oscillator stopped");
endmodule // sstc_top
`default_nettype wire

//--- verification/test_system_supply_tick_control.sv
// self-checking bench for the supply and tick control block
`timescale 1ns/1ps
`default_nettype none
module test_system_supply_tick_control;
   import sstc_pkg::*;
   localparam int unsigned SD = 20;
   logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [CMP_W-1:0] cmp = '0;
   logic [KEY_W-1:0] keys = '0;
   wire [31:0] prdata;
   wire pready, pslverr, chipReset, supplyIrq, tickIrq, wakeup, detectorOn, slowOscOn;
   wire [2:0] powerMode;
   wire [1:0] busDividerSelect;
   wire [5:0] obs = {slowOscOn, detectorOn, wakeup, tickIrq, supplyIrq, chipReset};
   int num_errors = 0, check_count = 0;
   logic [32:0] expQ[$];
   logic [32:0] e;
   logic [7:0] r;
   sstc_top #(.SLOW_DIV(SD)) i_sstc_top (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .analogCmp(cmp), .keyWakeInput(keys), .chipReset(chipReset), .supplyIrq(supplyIrq), .tickIrq(tickIrq),
      .wakeup(wakeup), .powerMode(powerMode), .busDividerSelect(busDividerSelect), .detectorOn(detectorOn),
      .slowOscOn(slowOscOn));
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] got);
      check_count++;
      if (got !== ex) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic test_done();
      if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // request held until pready is sampled high, released only after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge ref_clk);
      penable <= 1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      if (pready !== 1'b1) chk("pready", 1, pready);
      psel <= 0;
      penable <= 0;
      // one idle edge, so two transfers never drive psel twice in one step
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic err = 0);
      expQ.push_back({err, 24'h00_0000, ex});
      apb(0, a, 8'h00);
   endtask
   // bounded wait for one observed output to reach a level
   task automatic waitBit(input int b, input logic v, input int lim);
      int n;
      n = 0;
      while (obs[b] !== v && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      chk($sformatf("obs%0d", b), v, obs[b]);
   endtask
   // read results are compared in the cycle pready stands
   always @(posedge ref_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         e = expQ.pop_front();
         chk("prdata", e, {pslverr, prdata});
      end
   end
   initial begin
      #(60000 * 5);
      num_errors++;
      test_done();
   end
   initial begin
      void'($urandom(52707));
      repeat (10) @(posedge ref_clk);
      nrst <= 1;
      waitBit(0, 0, 20);
      chk("slowOsc", 1, slowOscOn);
      rd(OFS_STAT, 8'h82);
      rd(OFS_TICK, 8'h00);
      rd(OFS_CLK, 8'h00);
      rd(8'hF0, 8'h00, 1);
      for (int i = 0; i < 4; i++) begin
         r = 8'(i ^ ($urandom % 4));
         wr(OFS_CLK, r);
         rd(OFS_CLK, r & 8'h03);
         chk("busDiv", r[1:0], busDividerSelect);
      end
      wr(OFS_PWR1, 8'h05);
      cmp[C_DLO] <= 1;
      waitBit(1, 1, 10);
      rd(OFS_PWR1, 8'h85);
      cmp[C_DLO] <= 0;
      wr(OFS_PWR1, 8'h45);
      rd(OFS_PWR1, 8'h05);
      wr(OFS_PWR1, 8'h01);
      cmp[C_WLO] <= 1;
      repeat (6) @(posedge ref_clk);
      rd(OFS_PWR3, 8'h80);
      wr(OFS_PWR3, 8'h20);
      rd(OFS_PWR3, 8'h80);
      chk("noWarnIrq", 0, supplyIrq);
      cmp[C_WLO] <= 0;
      repeat (6) @(posedge ref_clk);
      wr(OFS_PWR3, 8'h20);
      rd(OFS_PWR3, 8'h00);
      chk("detOn", 1, detectorOn);
      wr(OFS_PWR1, 8'h09);
      wr(OFS_MODE, 8'h02);
      rd(OFS_MODE, 8'h09);
      wr(OFS_PWR1, 8'h01);
      wr(OFS_MODE, 8'h01);
      repeat (3) @(posedge ref_clk);
      chk("light", 3'b010, powerMode);
      chk("detOff", 0, detectorOn);
      keys <= 4'h1 << ($urandom % 4);
      waitBit(3, 1, 10);
      keys <= 4'h0;
      repeat (2) @(posedge ref_clk);
      chk("run", 3'b001, powerMode);
      // full period sweep; each period is 2^code slow ticks
      for (int c = 1; c < 8; c++) begin
         wr(OFS_TICK, 8'h50 | 8'(c));
         waitBit(2, 1, (SD << c) + SD + 20);
         rd(OFS_TICK, 8'h90 | 8'(c));
         wr(OFS_TICK, 8'h10 | 8'(c));
         rd(OFS_TICK, 8'h90 | 8'(c));
         wr(OFS_TICK, 8'h50 | 8'(c));
         rd(OFS_TICK, 8'h10 | 8'(c));
      end
      wr(OFS_TICK, 8'h30);
      rd(OFS_TICK, 8'h30);
      wr(OFS_TICK, 8'h71);
      waitBit(2, 1, (FAST_CYCLES << 4) + 20);
      wr(OFS_TICK, 8'h50);
      wr(OFS_TICK, 8'h10);
      repeat (300) @(posedge ref_clk);
      chk("tickOff", 0, tickIrq);
      wr(OFS_PWR1, 8'h03);
      cmp[C_DLO] <= 1;
      waitBit(0, 1, 10);
      repeat (20) @(posedge ref_clk);
      chk("held", 1, chipReset);
      cmp[C_DLO] <= 0;
      waitBit(0, 0, 10);
      rd(OFS_STAT, 8'h02);
      rd(OFS_PWR1, 8'h00);
      wr(OFS_OPT1, 8'h01);
      cmp[C_TLO] <= 1;
      wr(OFS_MODE, 8'h02);
      chk("deep", 3'b100, powerMode);
      cmp[C_TLO] <= 0;
      waitBit(3, 1, 10);
      repeat (4) @(posedge ref_clk);
      chk("runAgain", 3'b001, powerMode);
      test_done();
   end
endmodule // test_system_supply_tick_control
`default_nettype wire
